/* hdl/sfr_pkg.sv */
/*
 * Constants, command table and carrier types for the serial flash
 * fast-read engine.
 * Assumes it is compiled before every file that imports it.
 */
package sfr_pkg;

   // ***************************************************************
   //  read opcodes
   // ***************************************************************
   localparam logic [7:0] OP_FAST      = 8'h0B; // single lane fast read
   localparam logic [7:0] OP_DUAL_OUT  = 8'h3B; // dual output
   localparam logic [7:0] OP_QUAD_OUT  = 8'h6B; // quad output
   localparam logic [7:0] OP_DUAL_IO   = 8'hBB; // dual address and data
   localparam logic [7:0] OP_QUAD_IO   = 8'hEB; // quad address and data
   localparam logic [7:0] OP_WORD_QUAD = 8'hE7; // word quad i/o

   // ***************************************************************
   //  phase lengths, in serial clocks or bits
   // ***************************************************************
   localparam logic [4:0] OPCODE_CLKS   = 5'h08; // opcode is one byte on one lane
   localparam logic [4:0] ADDR_BITS     = 5'h18; // 24 address bits
   localparam logic [4:0] MODE_BITS     = 5'h08; // continuation mode byte
   localparam logic [3:0] FAST_DUMMY    = 4'h8;  // dummy clocks of output-only reads
   localparam logic [3:0] QUAD_IO_DUMMY = 4'h4; // dummy clocks after quad i/o mode
   localparam logic [3:0] WORD_DUMMY    = 4'h2;  // dummy clocks after word quad mode
   localparam logic [3:0] NO_DUMMY      = 4'h0;  // dual i/o goes straight to data

   // ***************************************************************
   //  field values
   // ***************************************************************
   localparam logic [1:0] CONT_KEEP      = 2'h2;  // select pair value that skips opcode
   localparam logic [7:0] WRAP_BASE_LEN  = 8'h08; // shortest wrap section in bytes
   localparam int         WRAP_DIS_POS   = 0;     // disable bit inside the wrap setting
   localparam logic [3:0] OE_N_OFF       = 4'hF;  // every lane released
   localparam logic [3:0] OE_N_SINGLE    = 4'hD;  // only lane one driven
   localparam logic [3:0] OE_N_DUAL      = 4'hC;  // lanes zero and one driven
   localparam logic [3:0] OE_N_QUAD      = 4'h0;  // all four lanes driven
   localparam int         MEM_LATENCY    = 1;     // read data arrive one cycle after rd
   localparam logic [5:0] PIN_IDLE       = 6'h10; // link clock low, select high, lanes low

   // ***************************************************************
   //  carrier types
   // ***************************************************************
   typedef struct packed {
      logic       valid;    // opcode is a supported read
      logic [2:0] addr_w;   // lanes used for address and mode
      logic [2:0] data_w;   // lanes used for data
      logic       has_mode; // mode byte follows the address
      logic [3:0] dummy;    // dummy clocks before data
      logic       needs_qe; // refused unless quad lanes are enabled
      logic       wrap_ok;  // burst wrap applies
   } sfr_cmd_s;

   typedef struct packed {
      logic        rd;   // one-cycle read strobe
      logic [23:0] addr; // byte address
   } sfr_mem_req_s;

   // decode one opcode byte into its command shape
   function automatic sfr_cmd_s sfr_decode(input logic [7:0] op);
      sfr_cmd_s c;
      c = '0;
      case (op)
         OP_FAST:      c = '{1'b1, 3'h1, 3'h1, 1'b0, FAST_DUMMY, 1'b0, 1'b0};
         OP_DUAL_OUT:  c = '{1'b1, 3'h1, 3'h2, 1'b0, FAST_DUMMY, 1'b0, 1'b0};
         OP_QUAD_OUT:  c = '{1'b1, 3'h1, 3'h4, 1'b0, FAST_DUMMY, 1'b1, 1'b0};
         OP_DUAL_IO:   c = '{1'b1, 3'h2, 3'h2, 1'b1, NO_DUMMY, 1'b0, 1'b0};
         OP_QUAD_IO:   c = '{1'b1, 3'h4, 3'h4, 1'b1, QUAD_IO_DUMMY, 1'b1, 1'b1};
         OP_WORD_QUAD: c = '{1'b1, 3'h4, 3'h4, 1'b1, WORD_DUMMY, 1'b1, 1'b1};
         default:      c = '0;
      endcase
      return c;
   endfunction

endpackage

/* hdl/sfr_sync.sv */
/*
 * Two-stage synchroniser for a bundle of asynchronous pins.
 * Assumes each bit is independent; no bundle coherence is promised.
 */
`timescale 1ns/1ps
`default_nettype none

module sfr_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   // pins in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q; // first stage, read only by the second

   // two flops; reset parks both at the pins' idle levels so that no
   // false select or edge is seen in the first cycles after reset
   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta_q   <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule
`default_nettype wire

/* hdl/sfr_wrap.sv */
/*
 * Next read address with optional burst wrap inside a 256-byte page.
 * Assumes the caller tells it whether the current command may wrap.
 */
`timescale 1ns/1ps
`default_nettype none

module sfr_wrap (
   // current address and setting
   input  wire logic [23:0] addr,
   input  wire logic [2:0]  wrap_setting,
   input  wire logic        wrap_ok,
   // following address
   output logic      [23:0] next_addr
);
   import sfr_pkg::*;

   logic [7:0] mask;   // low bits that move inside a section
   logic [7:0] low_up; // low byte plus one
   logic       wrap_on;

   // length field picks 8, 16, 32 or 64 bytes; disable bit turns it off
   always_comb begin
      mask    = 8'((WRAP_BASE_LEN << wrap_setting[2:1]) - 8'h01);
      low_up  = 8'(addr[7:0] + 8'h01);
      wrap_on = wrap_ok && !wrap_setting[WRAP_DIS_POS];
      if (wrap_on) begin
         next_addr = {addr[23:8], (addr[7:0] & ~mask) | (low_up & mask)};
      end else begin
         next_addr = 24'(addr + 24'h000001);
      end
   end

endmodule
`default_nettype wire

/* hdl/sfr_fast_read.sv */
/*
 * Fast-read command engine of a serial NOR flash: single, dual and quad
 * output reads, dual and quad i/o reads with continuation mode, and
 * burst wrap for quad i/o reads.
 * Assumes the serial clock is slow enough (>= 4 system clocks per
 * phase) to be sampled, and a byte memory that answers one cycle after
 * its read strobe.
 */
// What this block does
// RQ1: 0Bh: serial address, eight dummies, then data
// RQ2: host ignores output during dummy clocks
// RQ3: 3Bh: serial address, eight dummies, two-lane data
// RQ4: host releases lane zero before dual data
// RQ5: 6Bh: four-lane data, only with quad enable
// RQ6: host releases shared lanes before data
// RQ7: BBh: address and data on two lanes
// RQ8: mode byte follows address; upper nibble matters
// RQ9: BBh with pair 10 skips next opcode
// RQ10: other pair value restores full opcode decoding
// RQ11: reset command clears retained continuation state
// RQ12: EBh: four-lane address, four dummies, data
// RQ13: EBh accepted only with quad enable
// RQ14: EBh with pair 10 repeats without opcode
// RQ15: wrap stays inside aligned section until deselect
// RQ16: wrap disable bit and length field steer
// RQ17: E7h: even address, two dummy clocks; the code takes an odd address as given
// RQ18: E7h accepted only with quad enable
// RQ19: E7h with pair 10 repeats without opcode
// RQ20: word quad reads wrap like quad reads
// RQ21: ones for eight/sixteen clocks end continuation
// RQ22: length codes 8..64 bytes; disable bit off
// RQ23: address increments after each byte, MSB first
// RQ24: read ignored while a write cycle runs
// RQ25: highest lane carries highest remaining bit
// RQ26: deselect ends read and releases lanes
`timescale 1ns/1ps
`default_nettype none

module sfr_fast_read (
   // system clock and reset
   input  wire logic                  clk,
   input  wire logic                  resetn,
   // serial link pins
   input  wire logic                  spi_clk,
   input  wire logic                  chip_sel_n,
   input  wire logic [3:0]            lane_in,
   output logic      [3:0]            lane_out,
   output logic      [3:0]            lane_oe_n,
   // configuration and device state
   input  wire logic                  quad_lane_enable_bit,
   input  wire logic [2:0]            burst_wrap_setting,
   input  wire logic                  write_busy,
   // byte memory
   output sfr_pkg::sfr_mem_req_s      mem_req,
   input  wire logic [7:0]            mem_rdata,
   // status
   output logic                       continuation_active,
   output logic                       read_streaming
);
   import sfr_pkg::*;

   // ***************************************************************
   //  pin sampling
   // ***************************************************************
   typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA,
                             ST_IGNORE} sfr_state_e;

   logic       sclk_s;    // synchronised serial clock
   logic       cs_n_s;    // synchronised chip select
   logic [3:0] lane_s;    // synchronised lanes
   logic       sclk_d_q;  // previous serial clock level
   logic       rise;      // host samples-to-device edge
   logic       fall;      // device launch edge

   sfr_sync #(.WIDTH(6), .RST_VAL(PIN_IDLE)) u_sync (
      .clk      (clk),
      .resetn   (resetn),
      .async_in ({spi_clk, chip_sel_n, lane_in}),
      .sync_out ({sclk_s, cs_n_s, lane_s})
   );

   // edge finder works on the second stage only
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sclk_d_q <= 1'b0;
      end else begin
         sclk_d_q <= sclk_s;
      end
   end
   assign rise = sclk_s & ~sclk_d_q;
   assign fall = ~sclk_s & sclk_d_q;

   // ***************************************************************
   //  command shape and phase lengths
   // ***************************************************************
   sfr_state_e  state_q;     // frame phase
   logic [4:0]  cnt_q;       // clocks seen in the current phase
   logic [31:0] sh_q;        // collected opcode, address and mode bits
   logic [31:0] sh_in;       // collector after this edge
   logic [7:0]  op_q;        // opcode of the current or retained command
   sfr_cmd_s    cmd;         // shape of op_q
   sfr_cmd_s    dec_in;      // shape of the opcode being received
   logic [2:0]  in_w;        // lanes sampled in this phase
   logic [4:0]  phase_len;   // clocks in this phase
   logic        last;        // final clock of this phase
   logic        cont_q;      // next frame skips the opcode
   logic        wrap_on;     // wrap in force for this read

   assign cmd    = sfr_decode(op_q);
   assign dec_in = sfr_decode(sh_in[7:0]);
   assign in_w   = (state_q == ST_OPCODE) ? 3'h1 : cmd.addr_w;

   // new bits enter at the bottom; the highest lane is the highest bit
   always_comb begin
      case (in_w)
         3'h1:    sh_in = {sh_q[30:0], lane_s[0]}; // serial input pin is lane zero
         3'h2:    sh_in = {sh_q[29:0], lane_s[1:0]}; // RQ7
         default: sh_in = {sh_q[27:0], lane_s[3:0]}; // RQ12
      endcase
   end

   // address and mode clocks follow the lane count of the command
   always_comb begin
      case (state_q)
         ST_OPCODE: phase_len = OPCODE_CLKS;
         ST_ADDR:   phase_len = 5'(ADDR_BITS / in_w);
         ST_MODE:   phase_len = 5'(MODE_BITS / in_w); // RQ8
         ST_DUMMY:  phase_len = {1'b0, cmd.dummy};
         default:   phase_len = 5'h1F;
      endcase
   end
   assign last = rise && (cnt_q == 5'(phase_len - 5'h01));

   // ***************************************************************
   //  frame sequencer
   // ***************************************************************
   // deselect wins over everything but reset and returns the frame to idle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         cnt_q   <= 5'h00;
      end else if (cs_n_s) begin
         state_q <= ST_IDLE; // RQ26
         cnt_q   <= 5'h00;
      end else begin
         if (rise) begin
            cnt_q <= last ? 5'h00 : 5'(cnt_q + 5'h01);
         end
         case (state_q)
            ST_IDLE: begin
               cnt_q <= 5'h00;
               if (cont_q) begin
                  // a retained command starts straight at its address
                  state_q <= write_busy ? ST_IGNORE : ST_ADDR; // RQ9 RQ14 RQ19 RQ24
               end else begin
                  state_q <= ST_OPCODE; // RQ10
               end
            end
            ST_OPCODE: begin
               if (last) begin
                  if (write_busy || !dec_in.valid) begin
                     state_q <= ST_IGNORE; // RQ24
                  end else if (dec_in.needs_qe && !quad_lane_enable_bit) begin
                     state_q <= ST_IGNORE; // RQ5 RQ13 RQ18
                  end else begin
                     state_q <= ST_ADDR;
                  end
               end
            end
            ST_ADDR: begin
               if (last) begin
                  if (cmd.has_mode) begin
                     state_q <= ST_MODE; // RQ8
                  end else begin
                     state_q <= ST_DUMMY; // RQ1 RQ3
                  end
               end
            end
            ST_MODE: begin
               if (last) begin
                  state_q <= (cmd.dummy != NO_DUMMY) ? ST_DUMMY : ST_DATA; // RQ7 RQ12 RQ17
               end
            end
            ST_DUMMY: begin
               // nothing is driven here, the host must not read it
               if (last) begin
                  state_q <= ST_DATA; // RQ2
               end
            end
            default: begin
               state_q <= state_q; // data and ignore run until deselect
            end
         endcase
      end
   end

   // collector and opcode capture
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sh_q <= 32'h00000000;
         op_q <= 8'h00;
      end else if (state_q == ST_IDLE) begin
         sh_q <= 32'h00000000;
      end else if (rise && (state_q == ST_OPCODE || state_q == ST_ADDR || state_q == ST_MODE)) begin
         sh_q <= sh_in;
         if (state_q == ST_OPCODE && last) begin
            op_q <= sh_in[7:0];
         end
      end
   end

   // ***************************************************************
   //  continuation mode
   // ***************************************************************
   // only the select pair counts; a byte of ones also ends the mode,
   // which is how the reset command works in either lane width
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cont_q <= 1'b0;
      end else if (!cs_n_s && state_q == ST_MODE && last) begin
         cont_q <= (sh_in[5:4] == CONT_KEEP); // RQ9 RQ10 RQ11 RQ14 RQ19 RQ21
      end
   end
   assign continuation_active = cont_q;

   // ***************************************************************
   //  memory fetch and address advance
   // ***************************************************************
   logic [23:0] addr_q;    // address of the byte in nxt_q
   logic [23:0] next_addr; // following address, wrapped if enabled
   logic        rd_q;      // read strobe
   logic        pend_q;    // read data due this cycle
   logic [7:0]  nxt_q;     // prefetched byte
   logic [7:0]  so_q;      // byte being shifted out
   logic [2:0]  pos_q;     // bits of so_q already sent
   logic [7:0]  out_word;  // byte that supplies this edge
   logic [3:0]  dout;      // lanes for this edge
   logic [3:0]  doe_n;     // lane enables for this edge
   logic [3:0]  pos_sum;   // position after this edge
   logic        take;      // falling edge that starts a new byte

   assign wrap_on = cmd.wrap_ok && !burst_wrap_setting[WRAP_DIS_POS];
   assign take    = fall && !cs_n_s && (state_q == ST_DATA) && (pos_q == 3'h0);

   sfr_wrap u_wrap (
      .addr         (addr_q),
      .wrap_setting (burst_wrap_setting), // RQ16 RQ22
      .wrap_ok      (cmd.wrap_ok),        // RQ15 RQ20
      .next_addr    (next_addr)
   );

   // fetch the start byte as soon as the address is known, then one
   // byte ahead of the shifter so no edge waits on the memory
   always_ff @(posedge clk) begin
      if (!resetn) begin
         addr_q <= 24'h000000;
         rd_q   <= 1'b0;
         pend_q <= 1'b0;
         nxt_q  <= 8'h00;
      end else begin
         rd_q   <= 1'b0;
         pend_q <= rd_q;
         if (pend_q) begin
            nxt_q <= mem_rdata;
         end
         if (!cs_n_s && state_q == ST_ADDR && last) begin
            addr_q <= sh_in[23:0]; // RQ1
            rd_q   <= 1'b1;
         end else if (take) begin
            addr_q <= next_addr; // RQ23
            rd_q   <= 1'b1;
         end
      end
   end
   assign mem_req = '{rd: rd_q, addr: addr_q};

   // ***************************************************************
   //  data shifter
   // ***************************************************************
   assign out_word = (pos_q == 3'h0) ? nxt_q : so_q;
   assign pos_sum  = 4'({1'b0, pos_q} + {1'b0, cmd.data_w});

   // most significant remaining bits go out, top lane highest
   always_comb begin
      case (cmd.data_w)
         3'h1: begin
            dout  = {2'h0, out_word[7], 1'b0}; // RQ1
            doe_n = OE_N_SINGLE;
         end
         3'h2: begin
            dout  = {2'h0, out_word[7:6]}; // RQ3 RQ7 RQ25
            doe_n = OE_N_DUAL;
         end
         default: begin
            dout  = out_word[7:4]; // RQ5 RQ12 RQ25
            doe_n = OE_N_QUAD;
         end
      endcase
   end

   // lanes change only on falling edges; deselect releases them at once
   always_ff @(posedge clk) begin
      if (!resetn || cs_n_s || state_q != ST_DATA) begin
         lane_out  <= 4'h0;
         lane_oe_n <= OE_N_OFF; // RQ26
         so_q      <= 8'h00;
         pos_q     <= 3'h0;
      end else if (fall) begin
         lane_out  <= dout;
         lane_oe_n <= doe_n;
         so_q      <= 8'(out_word << cmd.data_w); // RQ23
         pos_q     <= (pos_sum == 4'h8) ? 3'h0 : pos_sum[2:0];
      end
   end
   assign read_streaming = (state_q == ST_DATA);

   // ***************************************************************
   //  checks
   // ***************************************************************
   logic [4:0] dum_seen_q; // dummy clocks counted in this frame

   always_ff @(posedge clk) begin
      if (!resetn || state_q == ST_IDLE) begin
         dum_seen_q <= 5'h00;
      end else if (rise && state_q == ST_DUMMY) begin
         dum_seen_q <= 5'(dum_seen_q + 5'h01);
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_mode_end;
      !cs_n_s && (state_q == ST_MODE) && last;
   endsequence
   sequence s_data_start;
      (state_q == ST_DATA) && ($past(state_q) != ST_DATA);
   endsequence

   a_fast_dummy_len: assert property (s_data_start ##0 (op_q == OP_FAST) |-> dum_seen_q == 5'h08) // RQ1
      else $error("fast read data began without eight dummy clocks");
   a_quad_dummy_len: assert property (s_data_start ##0 (op_q == OP_QUAD_IO) |-> dum_seen_q == 5'h04) // RQ12
      else $error("quad i/o data began without four dummy clocks");
   a_word_dummy_len: assert property (s_data_start ##0 (op_q == OP_WORD_QUAD) |-> dum_seen_q == 5'h02) // RQ17
      else $error("word quad data began without two dummy clocks");
   a_quad_gate: assert property (!cs_n_s && state_q == ST_OPCODE && last && dec_in.needs_qe
                                 && !quad_lane_enable_bit |=> state_q == ST_IGNORE) // RQ13
      else $error("quad read accepted with quad lanes disabled");
   a_busy_ignore: assert property (!cs_n_s && state_q == ST_OPCODE && last && write_busy
                                   |=> state_q == ST_IGNORE) // RQ24
      else $error("read accepted during a write cycle");
   a_cont_keep: assert property (s_mode_end ##0 (sh_in[5:4] == CONT_KEEP) |=> cont_q) // RQ9
      else $error("select pair 10 did not retain the command");
   a_cont_drop: assert property (s_mode_end ##0 (sh_in[5:4] != CONT_KEEP) |=> !cont_q) // RQ10
      else $error("continuation kept without select pair 10");
   a_cont_skip: assert property (state_q == ST_IDLE && !cs_n_s && cont_q && !write_busy
                                 |=> state_q == ST_ADDR) // RQ14
      else $error("retained command still expected an opcode");
   a_addr_incr: assert property (take && !wrap_on |=> addr_q == 24'($past(addr_q) + 24'h000001)) // RQ23
      else $error("read address did not advance by one byte");
   a_wrap_sect: assert property (take && wrap_on |=> addr_q[23:6] == $past(addr_q[23:6])) // RQ15
      else $error("wrapped read left its section");
   a_lane_order: assert property (take && cmd.data_w == 3'h4 |=> lane_out == $past(nxt_q[7:4])) // RQ25
      else $error("quad lanes not carrying the top nibble first");
   a_cs_release: assert property (cs_n_s |=> lane_oe_n == OE_N_OFF) // RQ26
      else $error("lanes still driven after deselect");

endmodule
`default_nettype wire

/* sim/sfr_host_model.sv */
/* serial host model: makes the link clock, chip select and lane levels.
   assumes clk paces every edge; link clock is 16 clk a period. */
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
   // pacing clock
   input  wire logic       clk,
   // serial link
   output logic            spi_clk,
   output logic            chip_sel_n,
   output logic      [3:0] lane_in,
   input  wire logic [3:0] lane_out,
   input  wire logic [3:0] lane_oe_n
);
   logic [3:0] hv; // host lane values
   logic       hd; // host drives its lanes
   logic       tg; // released lanes wander so a stale bit never passes
   initial begin
      spi_clk    = 1'b0; // link clock stands still between frames
      chip_sel_n = 1'b1;
      hv         = 4'h0;
      hd         = 1'b0;
      tg         = 1'b0;
   end
   always @(posedge clk) tg <= ~tg;
   // wired lane level: device first, then host, else a moving pattern
   always_comb for (int i = 0; i < 4; i++) lane_in[i] = !lane_oe_n[i] ? lane_out[i] : hd ? hv[i] : tg ^ i[0];
   // one link clock; drv low releases every lane, as in dummy and data
   task automatic tick(input logic [3:0] v, input logic drv, output logic [3:0] got);
      hv = v;
      hd = drv;
      repeat (8) @(posedge clk);
      #1 got = lane_in;
      spi_clk = 1'b1;
      repeat (4) @(posedge clk);
      #1 hd = 1'b0; // lanes let go well before the fall, after the device has sampled
      repeat (4) @(posedge clk);
      #1 spi_clk = 1'b0;
   endtask
   // select or deselect, then let the synchroniser settle
   task automatic sel(input logic on);
      @(posedge clk);
      #1 chip_sel_n = !on;
      hd = 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

/* sim/tb_sfr_fast_read.sv */
/* testbench of the fast-read engine: frames of every read kind.
   assumes a byte memory whose data is the low address byte xor 5A. */
`timescale 1ns/1ps
`default_nettype none
module tb_sfr_fast_read;
   import sfr_pkg::*;
   logic         clk, resetn, spi_clk, chip_sel_n, qe, busy, cont, strm;
   logic [3:0]   lin, lout, loen, g;
   logic [2:0]   wrap;   // burst wrap setting
   logic [7:0]   rdata;  // memory answer
   sfr_mem_req_s req;
   int           failures, comparisons;
   initial clk = 1'b0;
   always #2 clk = ~clk;
   // memory answers one cycle after its strobe
   always @(posedge clk) if (req.rd) rdata <= req.addr[7:0] ^ 8'h5A;
   sfr_fast_read sfr_fast_read_i (.clk(clk), .resetn(resetn), .spi_clk(spi_clk), .chip_sel_n(chip_sel_n),
      .lane_in(lin), .lane_out(lout), .lane_oe_n(loen), .quad_lane_enable_bit(qe), .burst_wrap_setting(wrap),
      .write_busy(busy), .mem_req(req), .mem_rdata(rdata), .continuation_active(cont), .read_streaming(strm));
   sfr_host_model sfr_host_model_i (.clk(clk), .spi_clk(spi_clk), .chip_sel_n(chip_sel_n), .lane_in(lin),
      .lane_out(lout), .lane_oe_n(loen));
   task automatic summarize();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // next byte address; wrap kept inside its aligned section
   function automatic logic [23:0] nxt(input logic [23:0] a, input logic w);
      logic [23:0] m;
      m = (24'(WRAP_BASE_LEN) << wrap[2:1]) - 24'h1;
      return (w && !wrap[WRAP_DIS_POS]) ? ((a & ~m) | ((a + 24'h1) & m)) : a + 24'h1;
   endfunction
   // n bits of d, msb first, w lanes a clock, top lane carries top bit
   task automatic shift(input int w, input int n, input logic [31:0] d);
      for (int i = n - w; i >= 0; i -= w) sfr_host_model_i.tick(4'((d >> i) & ((1 << w) - 1)), 1'b1, g);
   endtask
   // whole frame; ok low means the frame must be ignored
   task automatic frame(input logic [7:0] op, input logic skip, input int aw, input int dw, input int dum,
                        input int nb, input logic [23:0] a, input logic [7:0] m, input logic ok);
      logic [7:0] b;
      b = 8'h00;
      sfr_host_model_i.sel(1'b1);
      if (!skip) shift(1, 8, {24'h0, op});
      shift(aw, 24, {8'h0, a});
      if (aw > 1) shift(aw, 8, {24'h0, m});
      repeat (dum) sfr_host_model_i.tick(4'h0, 1'b0, g);
      chk({7'h0, strm}, {7'h0, ok});
      for (int k = 0; k < nb; k++) begin
         for (int j = 0; j < 8; j += dw) begin
            sfr_host_model_i.tick(4'h0, 1'b0, g);
            b = (b << dw) | 8'(dw == 1 ? {3'h0, g[1]} : dw == 2 ? {2'h0, g[1:0]} : g);
         end
         chk({4'h0, loen}, {4'h0, !ok ? OE_N_OFF : dw == 1 ? OE_N_SINGLE : dw == 2 ? OE_N_DUAL : OE_N_QUAD});
         if (ok) chk(b, a[7:0] ^ 8'h5A);
         a = nxt(a, aw == 4);
      end
      sfr_host_model_i.sel(1'b0);
      repeat (8) @(posedge clk);
      #1 chk({4'h0, loen}, {4'h0, OE_N_OFF});
      chk({7'h0, strm}, 8'h00);
   endtask
   // ones on every lane while selected
   task automatic ones(input int n);
      sfr_host_model_i.sel(1'b1);
      repeat (n) sfr_host_model_i.tick(4'hF, 1'b1, g);
      sfr_host_model_i.sel(1'b0);
      repeat (4) @(posedge clk);
      #1;
   endtask
   // hang guard
   initial begin
      repeat (90000) @(posedge clk);
      failures++;
      summarize();
   end
   initial begin
      resetn = 1'b0;
      qe = 1'b0;
      busy = 1'b0;
      wrap = 3'h1;
      rdata = 8'h00;
      failures = 0;
      comparisons = 0;
      repeat (10) @(posedge clk);
      #1 resetn = 1'b1;
      frame(OP_FAST, 0, 1, 1, 8, 2, 24'h0000FE, 8'h00, 1);
      frame(OP_DUAL_OUT, 0, 1, 2, 8, 2, 24'h123456, 8'h00, 1);
      frame(OP_QUAD_OUT, 0, 1, 4, 8, 1, 24'h000010, 8'h00, 0);
      frame(OP_QUAD_IO, 0, 4, 4, 4, 1, 24'h000010, 8'h00, 0);
      frame(OP_WORD_QUAD, 0, 4, 4, 2, 1, 24'h000010, 8'h00, 0);
      qe = 1'b1;
      frame(OP_QUAD_OUT, 0, 1, 4, 8, 2, 24'h000020, 8'h00, 1);
      frame(OP_DUAL_IO, 0, 2, 2, 0, 2, 24'h000030, 8'h2F, 1);
      chk({7'h0, cont}, 8'h01);
      frame(OP_DUAL_IO, 1, 2, 2, 0, 1, 24'h000040, 8'h00, 1);
      chk({7'h0, cont}, 8'h00);
      frame(OP_FAST, 0, 1, 1, 8, 1, 24'h000050, 8'h00, 1);
      wrap = 3'h0;
      frame(OP_QUAD_IO, 0, 4, 4, 4, 4, 24'h000106, 8'hA7, 1);
      wrap = 3'h1;
      frame(OP_QUAD_IO, 1, 4, 4, 4, 2, 24'h0001FF, 8'h20, 1);
      ones(8);
      chk({7'h0, cont}, 8'h00);
      wrap = 3'h6;
      frame(OP_WORD_QUAD, 0, 4, 4, 2, 3, 24'h00013E, 8'h20, 1);
      frame(OP_WORD_QUAD, 1, 4, 4, 2, 1, 24'h000300, 8'h00, 1);
      frame(OP_DUAL_IO, 0, 2, 2, 0, 1, 24'h000060, 8'h20, 1);
      ones(16);
      chk({7'h0, cont}, 8'h00);
      busy = 1'b1;
      frame(OP_FAST, 0, 1, 1, 8, 1, 24'h000070, 8'h00, 0);
      summarize();
   end
endmodule
`default_nettype wire
